// ### common/sifb_pkg.sv
// How it works
// - Enable register at 0h, bits 5,4,1,0
// - Flag register at 02h, bits 4..0
// - Unassigned bit positions hold no storage
// - Watchdog enable acts only in interval mode
// - Watchdog flag set on overflow or key violation
// - Watchdog flag cleared by power-up or pin reset
// - Oscillator fault sets its flag
// - Pin reset sets its flag; power-up clears it
// - Power-up sets the power-on flag
// - Soft reset clears enables, sets oscillator flag
// - Only power-on reset initialises three reset-cause flags
// - Power-on reset asserted at power-on and power-off
`default_nettype none
package sifb_pkg;
	// Byte offsets of the bank
	localparam logic [1:0] SIFB_OFS_IRQ_EN   = 2'h0;
	localparam logic [1:0] SIFB_OFS_EN_SPARE = 2'h1;
	localparam logic [1:0] SIFB_OFS_FLAGS    = 2'h2;
	localparam logic [1:0] SIFB_OFS_FL_SPARE = 2'h3;
	// Enable register bit positions
	localparam int SIFB_BIT_WDT_IE  = 0;
	localparam int SIFB_BIT_OSC_IE  = 1;
	localparam int SIFB_BIT_NMI_IE  = 4;
	localparam int SIFB_BIT_FLV_IE  = 5;
	// Flag register bit positions
	localparam int SIFB_BIT_WDT_FL  = 0;
	localparam int SIFB_BIT_OSC_FL  = 1;
	localparam int SIFB_BIT_POR_FL  = 2;
	localparam int SIFB_BIT_RST_FL  = 3;
	localparam int SIFB_BIT_NMI_FL  = 4;
	// Values after reset
	localparam logic SIFB_RST_IE      = 1'b0;
	localparam logic SIFB_RST_OSC_FL  = 1'b1;
	localparam logic SIFB_RST_NMI_FL  = 1'b0;
	localparam logic SIFB_RST_WDT_FL  = 1'b0;
	localparam logic SIFB_RST_RST_FL  = 1'b0;
	localparam logic SIFB_RST_POR_FL  = 1'b1;
	// Pin synchroniser depth
	localparam int SIFB_SYNC_STAGES = 3;
endpackage
`default_nettype wire

// ### verilog/sifb_pin_sync.sv
`default_nettype none
// Three-stage synchroniser; a change counts once stages two and three agree
module sifb_pin_sync (
	// Clock and reset
	input  wire logic core_clk_i,
	input  wire logic resetn_i,
	input  wire logic clk_en_i,
	// Pin and result
	input  wire logic pin_i,
	output logic      level_o
);
	import sifb_pkg::*;
	logic [SIFB_SYNC_STAGES-1:0] stage_q; // Shift chain, stage 0 metastable

	// Shift the pin through the chain
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			stage_q <= '0;
		end else if (clk_en_i) begin
			stage_q <= {stage_q[SIFB_SYNC_STAGES-2:0], pin_i};
		end
	end

	// Accept a new level only when the last two stages agree
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			level_o <= 1'b0;
		end else if (clk_en_i && (stage_q[1] == stage_q[2])) begin
			level_o <= stage_q[2];
		end
	end
endmodule
`default_nettype wire

// ### verilog/sifb_bank.sv
`default_nettype none
// System interrupt enable and event flag bank on the internal byte bus
module sifb_bank (
	// Clock, power-on reset, enable
	input  wire logic       core_clk_i,
	input  wire logic       resetn_i,
	input  wire logic       clk_en_i,
	// Soft system reset, synchronous with the core clock
	input  wire logic       soft_system_reset_i,
	// Byte bus
	input  wire logic [1:0] addr_i,
	input  wire logic       wr_en_i,
	input  wire logic [7:0] wdata_i,
	output logic      [7:0] rdata_o,
	// Event sources on the core clock
	input  wire logic       wdt_interval_mode_i,
	input  wire logic       wdt_overflow_i,
	input  wire logic       wdt_key_violation_i,
	input  wire logic       osc_fault_i,
	input  wire logic       flash_violation_i,
	// Reset/NMI pin events, asynchronous
	input  wire logic       pin_reset_evt_i,
	input  wire logic       pin_nmi_evt_i,
	// Gated interrupt requests
	output logic            wdt_irq_o,
	output logic            nmi_irq_o
);
	import sifb_pkg::*;

	// Only implemented bits are stored
	logic wdt_ie_q, osc_ie_q, nmi_ie_q, flv_ie_q; // Enable bits
	logic wdt_fl_q, osc_fl_q, por_fl_q, rst_fl_q, nmi_fl_q; // Flag bits
	logic pin_rst_lvl, pin_rst_lvl_q, pin_nmi_lvl, pin_nmi_lvl_q; // Synced pins
	logic pin_rst_rise, pin_nmi_rise; // One-cycle pin events
	logic wr_en, wr_fl; // Register write strobes

	// Pins come from outside the clock domain
	sifb_pin_sync u_rst_sync (
		.core_clk_i (core_clk_i),
		.resetn_i   (resetn_i),
		.clk_en_i   (clk_en_i),
		.pin_i      (pin_reset_evt_i),
		.level_o    (pin_rst_lvl)
	);
	sifb_pin_sync u_nmi_sync (
		.core_clk_i (core_clk_i),
		.resetn_i   (resetn_i),
		.clk_en_i   (clk_en_i),
		.pin_i      (pin_nmi_evt_i),
		.level_o    (pin_nmi_lvl)
	);

	// Edge detect on the filtered levels
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pin_rst_lvl_q <= 1'b0;
			pin_nmi_lvl_q <= 1'b0;
		end else if (clk_en_i) begin
			pin_rst_lvl_q <= pin_rst_lvl;
			pin_nmi_lvl_q <= pin_nmi_lvl;
		end
	end
	assign pin_rst_rise = pin_rst_lvl & ~pin_rst_lvl_q;
	assign pin_nmi_rise = pin_nmi_lvl & ~pin_nmi_lvl_q;

	assign wr_en = wr_en_i && (addr_i == SIFB_OFS_IRQ_EN);
	assign wr_fl = wr_en_i && (addr_i == SIFB_OFS_FLAGS);

	// Enables: power-on and soft reset both clear them
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wdt_ie_q <= SIFB_RST_IE;
			osc_ie_q <= SIFB_RST_IE;
			nmi_ie_q <= SIFB_RST_IE;
			flv_ie_q <= SIFB_RST_IE;
		end else if (clk_en_i) begin
			if (soft_system_reset_i) begin
				wdt_ie_q <= SIFB_RST_IE;
				osc_ie_q <= SIFB_RST_IE;
				nmi_ie_q <= SIFB_RST_IE;
				flv_ie_q <= SIFB_RST_IE;
			end else if (wr_en) begin
				wdt_ie_q <= wdata_i[SIFB_BIT_WDT_IE];
				osc_ie_q <= wdata_i[SIFB_BIT_OSC_IE];
				nmi_ie_q <= wdata_i[SIFB_BIT_NMI_IE];
				flv_ie_q <= wdata_i[SIFB_BIT_FLV_IE];
			end
		end
	end

	// Soft-reset flags; hardware set wins over a software clear
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			osc_fl_q <= SIFB_RST_OSC_FL;
			nmi_fl_q <= SIFB_RST_NMI_FL;
		end else if (clk_en_i) begin
			if (soft_system_reset_i) begin
				osc_fl_q <= SIFB_RST_OSC_FL;
				nmi_fl_q <= SIFB_RST_NMI_FL;
			end else begin
				osc_fl_q <= osc_fault_i | (wr_fl ? wdata_i[SIFB_BIT_OSC_FL] : osc_fl_q);
				nmi_fl_q <= pin_nmi_rise | (wr_fl ? wdata_i[SIFB_BIT_NMI_FL] : nmi_fl_q);
			end
		end
	end

	// Reset-cause flags: untouched by soft reset, only power-on initialises them
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wdt_fl_q <= SIFB_RST_WDT_FL;
			rst_fl_q <= SIFB_RST_RST_FL;
			por_fl_q <= SIFB_RST_POR_FL;
		end else if (clk_en_i) begin
			// Pin reset clears the watchdog cause, watchdog event sets it
			if (pin_rst_rise) begin
				wdt_fl_q <= 1'b0;
			end else if (wdt_overflow_i || wdt_key_violation_i) begin
				wdt_fl_q <= 1'b1;
			end else if (wr_fl) begin
				wdt_fl_q <= wdata_i[SIFB_BIT_WDT_FL];
			end
			rst_fl_q <= pin_rst_rise | (wr_fl ? wdata_i[SIFB_BIT_RST_FL] : rst_fl_q);
			if (wr_fl) begin
				por_fl_q <= wdata_i[SIFB_BIT_POR_FL];
			end
		end
	end

	// Read mux; unused bits and bytes read zero
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rdata_o <= 8'h00;
		end else if (clk_en_i) begin
			case (addr_i)
				SIFB_OFS_IRQ_EN: rdata_o <= {2'h0, flv_ie_q, nmi_ie_q, 2'h0, osc_ie_q, wdt_ie_q};
				SIFB_OFS_FLAGS:  rdata_o <= {3'h0, nmi_fl_q, rst_fl_q, por_fl_q, osc_fl_q, wdt_fl_q};
				default:         rdata_o <= 8'h00;
			endcase
		end
	end

	// Watchdog interrupt only in interval mode; NMI group from its own enables
	assign wdt_irq_o = wdt_ie_q & wdt_interval_mode_i & wdt_fl_q;
	assign nmi_irq_o = (nmi_ie_q & nmi_fl_q) | (osc_ie_q & osc_fl_q) | (flv_ie_q & flash_violation_i);

	// Assertions
	property p_soft_clears_en;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(clk_en_i && soft_system_reset_i) |=> !(wdt_ie_q | osc_ie_q | nmi_ie_q | flv_ie_q);
	endproperty
	a_soft_clears_en: assert property (p_soft_clears_en) else $error("enables not cleared");
	property p_soft_keeps_por;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(clk_en_i && soft_system_reset_i && !wr_fl) |=> $stable(por_fl_q);
	endproperty
	a_soft_keeps_por: assert property (p_soft_keeps_por) else $error("power-on flag moved");
	property p_wdt_set;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(clk_en_i && wdt_overflow_i && !pin_rst_rise) |=> wdt_fl_q;
	endproperty
	a_wdt_set: assert property (p_wdt_set) else $error("watchdog flag not set");
	property p_wdt_irq_mode;
		@(posedge core_clk_i) disable iff (!resetn_i)
		!wdt_interval_mode_i |-> !wdt_irq_o;
	endproperty
	a_wdt_irq_mode: assert property (p_wdt_irq_mode) else $error("irq in reset mode");
	property p_osc_set;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(clk_en_i && osc_fault_i) |=> osc_fl_q;
	endproperty
	a_osc_set: assert property (p_osc_set) else $error("osc flag not set");
	property p_pin_rst;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(clk_en_i && pin_rst_rise) |=> (rst_fl_q && !wdt_fl_q);
	endproperty
	a_pin_rst: assert property (p_pin_rst) else $error("pin reset flags wrong");
	property p_spare_zero;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(clk_en_i && addr_i[0]) |=> (rdata_o == 8'h00);
	endproperty
	a_spare_zero: assert property (p_spare_zero) else $error("spare byte nonzero");
	property p_unused_bits;
		@(posedge core_clk_i) disable iff (!resetn_i)
		rdata_o[7:6] == 2'b00;
	endproperty
	a_unused_bits: assert property (p_unused_bits) else $error("unused bits set");

	// Enable write: a byte with all four data bits set must leave all four enables set
	sequence s_ie_write;
		clk_en_i && wr_en && !soft_system_reset_i;
	endsequence
	sequence s_ie_all_ones;
		wdata_i[SIFB_BIT_WDT_IE] && wdata_i[SIFB_BIT_OSC_IE]
			&& wdata_i[SIFB_BIT_NMI_IE] && wdata_i[SIFB_BIT_FLV_IE];
	endsequence
	property p_ie_write;
		@(posedge core_clk_i) disable iff (!resetn_i)
		s_ie_write ##0 s_ie_all_ones |=> (wdt_ie_q && osc_ie_q && nmi_ie_q && flv_ie_q);
	endproperty
	a_ie_write: assert property (p_ie_write) else $error("enable write lost");

	// Enable read-back: each bit in its own column, the gap at bits 3 and 2 reads zero
	sequence s_rd_ie;
		clk_en_i && (addr_i == SIFB_OFS_IRQ_EN);
	endsequence
	property p_ie_rd;
		@(posedge core_clk_i) disable iff (!resetn_i)
		s_rd_ie |=> (rdata_o[SIFB_BIT_WDT_IE] == $past(wdt_ie_q))
			&& (rdata_o[SIFB_BIT_OSC_IE] == $past(osc_ie_q))
			&& (rdata_o[SIFB_BIT_NMI_IE] == $past(nmi_ie_q))
			&& (rdata_o[SIFB_BIT_FLV_IE] == $past(flv_ie_q))
			&& (rdata_o[3:2] == 2'h0);
	endproperty
	a_ie_rd: assert property (p_ie_rd) else $error("enable byte misplaced");

	// Flag read-back: a swapped column would hand software the wrong reset cause
	sequence s_rd_flags;
		clk_en_i && (addr_i == SIFB_OFS_FLAGS);
	endsequence
	property p_flags_rd;
		@(posedge core_clk_i) disable iff (!resetn_i)
		s_rd_flags |=> (rdata_o[SIFB_BIT_WDT_FL] == $past(wdt_fl_q))
			&& (rdata_o[SIFB_BIT_OSC_FL] == $past(osc_fl_q))
			&& (rdata_o[SIFB_BIT_POR_FL] == $past(por_fl_q))
			&& (rdata_o[SIFB_BIT_RST_FL] == $past(rst_fl_q))
			&& (rdata_o[SIFB_BIT_NMI_FL] == $past(nmi_fl_q))
			&& (rdata_o[7:5] == 3'h0);
	endproperty
	a_flags_rd: assert property (p_flags_rd) else $error("flag byte misplaced");

	// Soft reset with no cause event or write pending keeps the watchdog and pin-reset cause flags
	sequence s_soft_quiet;
		clk_en_i && soft_system_reset_i && !wr_fl && !pin_rst_rise;
	endsequence
	sequence s_no_wdt_evt;
		!wdt_overflow_i && !wdt_key_violation_i;
	endsequence
	property p_soft_keeps_cause;
		@(posedge core_clk_i) disable iff (!resetn_i)
		s_soft_quiet ##0 s_no_wdt_evt |=> ($stable(wdt_fl_q) && $stable(rst_fl_q));
	endproperty
	a_soft_keeps_cause: assert property (p_soft_keeps_cause) else $error("cause flag moved");

	// Key violation sets the watchdog flag just as an overflow does
	property p_wdt_key;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(clk_en_i && wdt_key_violation_i && !pin_rst_rise) |=> wdt_fl_q;
	endproperty
	a_wdt_key: assert property (p_wdt_key) else $error("key violation missed");

	// Filtered pin edge sets the pin flag unless soft reset clears it that cycle
	sequence s_pin_nmi_evt;
		clk_en_i && pin_nmi_rise && !soft_system_reset_i;
	endsequence
	property p_nmi_set;
		@(posedge core_clk_i) disable iff (!resetn_i)
		s_pin_nmi_evt |=> nmi_fl_q;
	endproperty
	a_nmi_set: assert property (p_nmi_set) else $error("pin flag not set");
endmodule
`default_nettype wire

// ### test/sifb_bank_tb_top.sv
`default_nettype none
// Compares two values, counts the check, reports a mismatch at once
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
	$display("wrong value %s expected %h seen %h", nm, e, g); end end
module sifb_bank_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import sifb_pkg::*;
	// Clock, reset and bus
	logic       core_clk_i = 1'b0;
	logic       resetn_i = 1'b0;
	logic       clk_en_i = 1'b1;
	logic       soft_system_reset_i = 1'b0;
	logic [1:0] addr_i = 2'h0;
	logic       wr_en_i = 1'b0;
	logic [7:0] wdata_i = 8'h00;
	logic [7:0] rdata_o;
	// Event sources
	logic       wdt_interval_mode_i = 1'b0;
	logic       wdt_overflow_i = 1'b0;
	logic       wdt_key_violation_i = 1'b0;
	logic       osc_fault_i = 1'b0;
	logic       flash_violation_i = 1'b0;
	logic       pin_reset_evt_i = 1'b0;
	logic       pin_nmi_evt_i = 1'b0;
	logic       wdt_irq_o;
	logic       nmi_irq_o;
	// Bench bookkeeping: expected {byte, wdt irq, nmi irq} per read
	logic [9:0] exp_q[$];
	logic [9:0] exp_v;
	logic       rd_req = 1'b0;
	logic       rd_seen = 1'b0;
	int         miscompares = 0;
	int         samples_checked = 0;
	int         cycles = 0;
	logic [7:0] rnd;
	sifb_bank u_sifb_bank (
		.core_clk_i(core_clk_i), .resetn_i(resetn_i), .clk_en_i(clk_en_i),
		.soft_system_reset_i(soft_system_reset_i), .addr_i(addr_i), .wr_en_i(wr_en_i),
		.wdata_i(wdata_i), .rdata_o(rdata_o), .wdt_interval_mode_i(wdt_interval_mode_i),
		.wdt_overflow_i(wdt_overflow_i), .wdt_key_violation_i(wdt_key_violation_i),
		.osc_fault_i(osc_fault_i), .flash_violation_i(flash_violation_i),
		.pin_reset_evt_i(pin_reset_evt_i), .pin_nmi_evt_i(pin_nmi_evt_i),
		.wdt_irq_o(wdt_irq_o), .nmi_irq_o(nmi_irq_o));
	// 200 MHz core clock
	always #2.5 core_clk_i = ~core_clk_i;
	// Prints the counts and the verdict, then stops
	task test_done();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Idle edges; every task drives the strobes once per edge to avoid double assignment
	task cyc(input int n);
		repeat (n) begin
			@(posedge core_clk_i);
			rd_req  <= 1'b0;
			wr_en_i <= 1'b0;
		end
	endtask
	// One byte write, taken at the following edge
	task wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge core_clk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_en_i <= 1'b1;
		rd_req  <= 1'b0;
	endtask
	// One read; the monitor checks it one edge later
	task rd(input logic [1:0] a, input logic [9:0] e);
		@(posedge core_clk_i);
		addr_i  <= a;
		wr_en_i <= 1'b0;
		rd_req  <= 1'b1;
		exp_q.push_back(e);
	endtask
	// Read data is registered, so the check trails the request by one edge
	always @(posedge core_clk_i) rd_seen <= rd_req;
	// Monitor: settled outputs at the falling edge against the oldest note
	always @(negedge core_clk_i) begin
		if (rd_seen) begin
			exp_v = exp_q.pop_front();
			`CHK("rdata_o", exp_v[9:2], rdata_o)
			`CHK("wdt_irq_o", exp_v[1], wdt_irq_o)
			`CHK("nmi_irq_o", exp_v[0], nmi_irq_o)
		end
	end
	// Hang guard; the whole run needs well under a thousand edges
	always @(posedge core_clk_i) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			test_done();
		end
	end
	// Main sequence
	initial begin
		void'($urandom(87));
		repeat (12) @(posedge core_clk_i);
		resetn_i <= 1'b1;
		// Reset values, spare bytes read zero
		rd(2'h0, 10'h000); rd(2'h1, 10'h000); rd(2'h2, 10'h018); rd(2'h3, 10'h000);
		// Only assigned bits store; spare bytes ignore writes
		wr(2'h0, 8'hff); wr(2'h1, 8'hff); wr(2'h3, 8'hff);
		rd(2'h0, 10'h0cd); rd(2'h1, 10'h001); rd(2'h3, 10'h001);
		wdt_interval_mode_i <= 1'b1;
		wr(2'h2, 8'hff);
		rd(2'h2, 10'h07f);
		cyc(2);
		wdt_interval_mode_i <= 1'b0;
		rd(2'h2, 10'h07d);
		wr(2'h2, 8'h00);
		rd(2'h2, 10'h000);
		// Random enable patterns
		repeat (8) begin
			rnd = 8'($urandom());
			wr(2'h0, rnd);
			rd(2'h0, {rnd & 8'h33, 2'b00});
		end
		wr(2'h0, 8'h33);
		wdt_interval_mode_i <= 1'b1;
		// Watchdog overflow and key violation each set the watchdog flag
		cyc(2); wdt_overflow_i <= 1'b1; cyc(1); wdt_overflow_i <= 1'b0;
		rd(2'h2, 10'h006); wr(2'h2, 8'h00);
		cyc(2); wdt_key_violation_i <= 1'b1; cyc(1); wdt_key_violation_i <= 1'b0;
		rd(2'h2, 10'h006); wr(2'h2, 8'h00);
		cyc(2); osc_fault_i <= 1'b1; cyc(1); osc_fault_i <= 1'b0;
		rd(2'h2, 10'h009); wr(2'h2, 8'h00);
		flash_violation_i <= 1'b1;
		rd(2'h2, 10'h001);
		cyc(2); flash_violation_i <= 1'b0;
		// Pin reset clears the watchdog flag and sets its own
		wr(2'h2, 8'h01);
		pin_reset_evt_i <= 1'b1; cyc(8);
		rd(2'h2, 10'h020);
		cyc(2); pin_reset_evt_i <= 1'b0; pin_nmi_evt_i <= 1'b1; cyc(8);
		rd(2'h2, 10'h061);
		// Frozen clock enable drops a write
		cyc(2); pin_nmi_evt_i <= 1'b0; clk_en_i <= 1'b0;
		wr(2'h0, 8'h00); cyc(1); clk_en_i <= 1'b1;
		rd(2'h0, 10'h0cd);
		// Soft reset: enables clear, oscillator flag sets, cause flags kept
		wr(2'h2, 8'h1d); cyc(1); soft_system_reset_i <= 1'b1; cyc(1);
		soft_system_reset_i <= 1'b0;
		rd(2'h0, 10'h000); rd(2'h2, 10'h03c);
		// Power-on reset in mid-run restores the power-up values
		wr(2'h0, 8'h33); wr(2'h2, 8'h1d); cyc(2);
		resetn_i <= 1'b0; cyc(3); resetn_i <= 1'b1;
		rd(2'h2, 10'h018); rd(2'h0, 10'h000);
		cyc(3);
		test_done();
	end
endmodule
`default_nettype wire
